// ==== logic/psram_bus_refresh_config.sv ====
// Configuration registers, deep-sleep control and burst latency timing.
// Assumes the address/data pins are already decoded into load strobes.
`default_nettype none

module psram_bus_refresh_config
    import psram_cfg_pkg::*;
#(
    parameter int EXIT_CYCLES = EXIT_CYC,
    parameter int INIT_CYCLES = INIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_config_reg_enable,
    input wire logic [1:0] i_addr_sel,
    input wire logic i_seq_valid,
    input wire logic [15:0] i_seq_select,
    input wire logic i_wr,
    input wire logic [15:0] i_muxed_addr_data_lines,
    input wire logic i_cs_n,
    input wire logic i_burst_start,
    input wire logic i_refresh_busy,
    output logic [15:0] o_bus_config_reg,
    output logic [15:0] o_refresh_config_reg,
    output logic [15:0] o_rdata,
    output logic [1:0] o_drive_strength,
    output logic [2:0] o_partial_refresh_select,
    output logic o_sync_mode,
    output logic o_deep_sleep_mode,
    output logic o_init_busy,
    output logic o_wait,
    output logic o_data_valid
);
    // The one counter shared by sleep exit and init is sixteen bits wide, so larger counts cannot work.
    if (EXIT_CYCLES < 1 || EXIT_CYCLES > 65535 ||
        INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_counts
        $error("Cycle counts out of range.");
    end

    logic [15:0] bus_q, bus_d, ref_q, ref_d, rd_q, rd_d;
    logic sleep_q, sleep_d, init_q, init_d, cs_n_q;
    logic [15:0] cnt_q, cnt_d;
    burst_e st_q, st_d;
    logic [3:0] lat_q, lat_d;
    logic wait_int_q, wait_int_d, valid_q, valid_d;
    logic sel_bus, sel_ref;

    // Latency in clocks for a code, doubled on a refresh collision except code eight, whose 16 wraps to 0.
    function automatic logic [3:0] lat_of(input logic [2:0] code,
                                          input logic coll);
        logic [3:0] n;
        n = (code == LAT_CODE_EIGHT) ? LAT_EIGHT : {1'b0, code};
        lat_of = coll ? 4'(n * 2) : n;
    endfunction

    always_comb begin
        sel_bus = (i_config_reg_enable && i_addr_sel == SEL_BUS) ||
                  (i_seq_valid && i_seq_select == SEQ_BUS);
        sel_ref = (i_config_reg_enable && i_addr_sel == SEL_REFRESH) ||
                  (i_seq_valid && i_seq_select == SEQ_REFRESH);
        bus_d = bus_q;
        ref_d = ref_q;
        rd_d = rd_q;
        sleep_d = sleep_q;
        init_d = init_q;
        cnt_d = cnt_q;
        if (!sleep_q && sel_bus && i_wr) begin
            bus_d = i_muxed_addr_data_lines;
        end
        if (!sleep_q && sel_ref && i_wr) begin
            ref_d = i_muxed_addr_data_lines;
        end
        if (sel_bus && !i_wr) begin
            rd_d = bus_q;
        end else if (sel_ref && !i_wr) begin
            rd_d = ref_q;
        end
        if (!sleep_q && !ref_q[SLEEP_BIT] && i_cs_n && !cs_n_q) begin
            sleep_d = 1'b1;
            cnt_d = '0;
        end else if (sleep_q) begin
            if (!i_cs_n) begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(EXIT_CYCLES - 1)) begin
                    sleep_d = 1'b0;
                    ref_d[SLEEP_BIT] = 1'b1;
                    init_d = 1'b1;
                    cnt_d = '0;
                end
            end else begin
                cnt_d = '0;
            end
        end else if (init_q) begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == 16'(INIT_CYCLES - 1)) begin
                init_d = 1'b0;
                cnt_d = '0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_q <= BUS_CFG_RESET;
            ref_q <= REF_CFG_RESET;
            rd_q <= '0;
            sleep_q <= 1'b0;
            init_q <= 1'b0;
            cnt_q <= '0;
            cs_n_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            ref_q <= ref_d;
            rd_q <= rd_d;
            sleep_q <= sleep_d;
            init_q <= init_d;
            cnt_q <= cnt_d;
            cs_n_q <= i_cs_n;
        end
    end

    // The wait output runs one clock ahead of data when the config bit
    // is set; otherwise it is delayed a clock and moves together with the
    // data, so the controller takes the data on the edge after it.
    always_comb begin
        st_d = st_q;
        lat_d = lat_q;
        wait_int_d = wait_int_q;
        valid_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                wait_int_d = 1'b0;
                if (i_burst_start && !bus_q[ASYNC_BIT] && !sleep_q &&
                    !init_q) begin
                    // Fixed mode already covers refresh, so no stretch.
                    lat_d = lat_of(bus_q[LAT_LSB +: 3],
                                   i_refresh_busy &&
                                   !bus_q[FIXED_LAT_BIT]);
                    wait_int_d = 1'b1;
                    st_d = ST_LAT;
                end
            end
            ST_LAT: begin
                lat_d = lat_q - 4'h1;
                // Releasing wait on the last count puts it one clock ahead.
                if (lat_q <= 4'h1) begin
                    wait_int_d = 1'b0;
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                valid_d = 1'b1;
                wait_int_d = 1'b0;
                if (i_cs_n) begin
                    st_d = ST_IDLE;
                    valid_d = 1'b0;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            lat_q <= '0;
            wait_int_q <= 1'b0;
            valid_q <= 1'b0;
            o_wait <= 1'b0;
            o_data_valid <= 1'b0;
            o_bus_config_reg <= BUS_CFG_RESET;
            o_refresh_config_reg <= REF_CFG_RESET;
            o_rdata <= '0;
            o_drive_strength <= BUS_CFG_RESET[DRIVE_LSB +: 2];
            o_partial_refresh_select <= REF_CFG_RESET[2:0];
            o_sync_mode <= 1'b0;
            o_deep_sleep_mode <= 1'b0;
            o_init_busy <= 1'b0;
        end else begin
            st_q <= st_d;
            lat_q <= lat_d;
            wait_int_q <= wait_int_d;
            valid_q <= valid_d;
            o_wait <= (bus_q[WAIT_CFG_BIT] ? wait_int_d : wait_int_q) ^
                      !bus_q[WAIT_POL_BIT];
            o_data_valid <= valid_d;
            o_bus_config_reg <= bus_d;
            o_refresh_config_reg <= ref_d;
            o_rdata <= rd_d;
            o_drive_strength <= bus_d[DRIVE_LSB +: 2];
            o_partial_refresh_select <= ref_d[2:0];
            o_sync_mode <= !bus_d[ASYNC_BIT];
            o_deep_sleep_mode <= sleep_d;
            o_init_busy <= init_d;
        end
    end

    property p_sleep_exit;
        @(posedge i_clk) disable iff (i_rst)
        (sleep_q && !sleep_d) |=> (ref_q[SLEEP_BIT] && init_q);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("Deep sleep exit did not set bit and start init.");

    property p_sleep_keep;
        @(posedge i_clk) disable iff (i_rst)
        sleep_q |=> ($stable(bus_q) && $stable(ref_q[15:5]) &&
                     $stable(ref_q[3:0]));
    endproperty
    a_sleep_keep: assert property (p_sleep_keep)
        else $error("Configuration changed during deep sleep.");

    property p_sleep_entry;
        @(posedge i_clk) disable iff (i_rst)
        (!sleep_q && !ref_q[SLEEP_BIT] && i_cs_n && !cs_n_q) |=> sleep_q;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("Deep sleep not entered.");

    property p_ref_write;
        @(posedge i_clk) disable iff (i_rst)
        (!sleep_q && sel_ref && !sel_bus && i_wr && !i_cs_n)
            |=> ref_q == $past(i_muxed_addr_data_lines);
    endproperty
    a_ref_write: assert property (p_ref_write)
        else $error("Refresh register not written as given.");

    property p_async_idle;
        @(posedge i_clk) disable iff (i_rst)
        bus_q[ASYNC_BIT] && st_q == ST_IDLE |=> st_q == ST_IDLE;
    endproperty
    a_async_idle: assert property (p_async_idle)
        else $error("Burst started in asynchronous mode.");

    sequence s_start_lat3;
        st_q == ST_IDLE && i_burst_start && !bus_q[ASYNC_BIT] && !sleep_q
            && !init_q && bus_q[LAT_LSB +: 3] == 3'h3 && !i_refresh_busy;
    endsequence
    property p_lat3;
        @(posedge i_clk) disable iff (i_rst)
        s_start_lat3 ##1 !i_cs_n [*4] |=> valid_q;
    endproperty
    a_lat3: assert property (p_lat3)
        else $error("First data not after three clocks.");

    property p_coll;
        @(posedge i_clk) disable iff (i_rst)
        (st_q == ST_IDLE && st_d == ST_LAT && i_refresh_busy &&
         !bus_q[FIXED_LAT_BIT] && bus_q[LAT_LSB +: 3] == 3'h2)
            |=> lat_q == 4'h4;
    endproperty
    a_coll: assert property (p_coll)
        else $error("Collision latency not stretched.");

    property p_pol;
        @(posedge i_clk) disable iff (i_rst)
        (st_q == ST_IDLE && st_d == ST_IDLE && $stable(bus_q[WAIT_POL_BIT]))
            |=> o_wait == !$past(bus_q[WAIT_POL_BIT]);
    endproperty
    a_pol: assert property (p_pol)
        else $error("Idle wait level has wrong polarity.");

    sequence s_last_lat;
        st_q == ST_LAT && st_d == ST_DATA;
    endsequence
    sequence s_wait_on;
        o_wait == bus_q[WAIT_POL_BIT];
    endsequence
    sequence s_wait_off;
        o_wait == !bus_q[WAIT_POL_BIT];
    endsequence

    property p_wait_early;
        @(posedge i_clk) disable iff (i_rst)
        s_last_lat ##0 bus_q[WAIT_CFG_BIT] |->
            s_wait_on ##1 (s_wait_off ##0 !o_data_valid) ##1 o_data_valid;
    endproperty
    a_wait_early: assert property (p_wait_early)
        else $error("Wait not released one clock before data.");

    property p_wait_late;
        @(posedge i_clk) disable iff (i_rst)
        s_last_lat ##0 !bus_q[WAIT_CFG_BIT] |->
            ##1 s_wait_on ##1 (s_wait_off ##0 o_data_valid);
    endproperty
    a_wait_late: assert property (p_wait_late)
        else $error("Wait not released together with data.");
endmodule
`default_nettype wire

// ==== logic/psram_cfg_pkg.sv ====
// Constants for the pseudo-static RAM configuration register block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
`default_nettype none
package psram_cfg_pkg;
    localparam int CLK_MHZ = 20;
    localparam logic [15:0] BUS_CFG_RESET = 16'h9D1F;
    localparam logic [15:0] REF_CFG_RESET = 16'h0010;
    localparam logic [1:0] SEL_REFRESH = 2'h0;
    localparam logic [1:0] SEL_BUS = 2'h2;
    localparam logic [15:0] SEQ_REFRESH = 16'h0000;
    localparam logic [15:0] SEQ_BUS = 16'h0001;
    localparam int DRIVE_LSB = 4;
    localparam int WAIT_CFG_BIT = 8;
    localparam int WAIT_POL_BIT = 10;
    localparam int LAT_LSB = 11;
    localparam int FIXED_LAT_BIT = 14;
    localparam int ASYNC_BIT = 15;
    localparam int SLEEP_BIT = 4;
    localparam int EXIT_US = 10;
    localparam int INIT_US = 150;
    localparam int EXIT_CYC = EXIT_US * CLK_MHZ;
    localparam int INIT_CYC = INIT_US * CLK_MHZ;
    localparam logic [2:0] LAT_CODE_EIGHT = 3'h0;
    localparam logic [3:0] LAT_EIGHT = 4'h8;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LAT = 2'b01,
        ST_DATA = 2'b11
    } burst_e;
endpackage
`default_nettype wire

// ==== verif/psram_host_model.sv ====
// Host controller model: chip select, burst start and refresh collision.
// Assumes it is called at falling edges of the device clock.
`default_nettype none
module psram_host_model (
    input wire logic i_clk,
    input wire logic i_wait,
    input wire logic i_data_valid,
    output logic o_cs_n,
    output logic o_burst_start,
    output logic o_refresh_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cs_n = 1'b0;
        o_burst_start = 1'b0;
        o_refresh_busy = 1'b0;
    end
    task automatic set_cs(input logic v);
        o_cs_n = v;
    endtask
    // The host must watch wait, since a collision may stretch the latency.
    task automatic burst(input logic coll, output int lat, output int wlat);
        logic idle;
        idle = i_wait;
        o_burst_start = 1'b1;
        o_refresh_busy = coll;
        @(negedge i_clk);
        o_burst_start = 1'b0;
        o_refresh_busy = 1'b0;
        lat = 0;
        wlat = 0;
        do begin
            @(negedge i_clk);
            lat++;
            if (wlat == 0 && i_wait === idle) wlat = lat;
        end while (i_data_valid !== 1'b1 && lat < 40);
        o_cs_n = 1'b1;
        repeat (2) @(negedge i_clk);
        o_cs_n = 1'b0;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ==== verif/test_psram_bus_refresh_config.sv ====
// Testbench: register access, burst latency and deep sleep scenarios.
// Assumes the package, the design and the host model are compiled first.
`default_nettype none
module test_psram_bus_refresh_config import psram_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst, config_reg_enable, seq_valid, wr, cs_n, burst_start, refresh_busy;
    logic [1:0] addr_sel, drive;
    logic [15:0] seq_sel, wdata, bus_q, ref_q, rdata;
    logic [2:0] part;
    logic sync, sleep, init_busy, wait_o, valid;
    int mismatches = 0;
    int comparisons = 0;
    int lat, wlat;
    always #25 clk = ~clk;
    psram_bus_refresh_config #(.EXIT_CYCLES(4), .INIT_CYCLES(8)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_config_reg_enable(config_reg_enable),
        .i_addr_sel(addr_sel), .i_seq_valid(seq_valid),
        .i_seq_select(seq_sel), .i_wr(wr),
        .i_muxed_addr_data_lines(wdata), .i_cs_n(cs_n),
        .i_burst_start(burst_start), .i_refresh_busy(refresh_busy),
        .o_bus_config_reg(bus_q), .o_refresh_config_reg(ref_q),
        .o_rdata(rdata), .o_drive_strength(drive),
        .o_partial_refresh_select(part), .o_sync_mode(sync),
        .o_deep_sleep_mode(sleep), .o_init_busy(init_busy),
        .o_wait(wait_o), .o_data_valid(valid));
    psram_host_model host (.i_clk(clk), .i_wait(wait_o),
        .i_data_valid(valid), .o_cs_n(cs_n),
        .o_burst_start(burst_start), .o_refresh_busy(refresh_busy));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access by pin or by software sequence, entered at a falling edge.
    task automatic acc(input logic sq, input logic bus, input logic w,
                       input logic [15:0] d);
        config_reg_enable = !sq;
        addr_sel = bus ? SEL_BUS : SEL_REFRESH;
        seq_valid = sq;
        seq_sel = bus ? SEQ_BUS : SEQ_REFRESH;
        wr = w;
        wdata = d;
        @(negedge clk);
        config_reg_enable = 1'b0;
        seq_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic burst_chk(input logic fix, input logic [2:0] code,
                             input logic coll, input logic wc,
                             input logic pol);
        int n;
        n = (code == 3'h0) ? 8 : int'(code);
        if (!fix && coll) n = 2 * n;
        acc(1'b0, 1'b1, 1'b1, {1'b0, fix, code, pol, 1'b0, wc, 8'h1F});
        chk({15'h0, sync}, 16'h0001);
        chk({15'h0, wait_o}, {15'h0, !pol});
        host.burst(coll, lat, wlat);
        chk(16'(lat), 16'(n + 1));
        chk(16'(wlat), 16'(wc ? lat - 1 : lat));
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        {config_reg_enable, seq_valid, wr, addr_sel, seq_sel, wdata} = '0;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(bus_q, BUS_CFG_RESET);
        chk(ref_q, REF_CFG_RESET);
        chk({14'h0, drive}, 16'h0001);
        chk({15'h0, sync}, 16'h0000);
        $display("test reset done");
        for (int p = 0; p < 8; p++) begin
            acc(p[0], 1'b0, 1'b1, 16'h0010 | 16'(p));
            chk({13'h0, part}, 16'(p));
            acc(!p[0], 1'b0, 1'b0, 16'h0000);
            chk(rdata, 16'h0010 | 16'(p));
        end
        for (int d = 0; d < 3; d++) begin
            acc(d[0], 1'b1, 1'b1, 16'h9D0F | 16'(d << 4));
            chk({14'h0, drive}, 16'(d));
            acc(!d[0], 1'b1, 1'b0, 16'h0000);
            chk(rdata, 16'h9D0F | 16'(d << 4));
        end
        for (int a = 1; a < 4; a += 2) begin
            config_reg_enable = 1'b1;
            addr_sel = 2'(a);
            wr = 1'b1;
            wdata = 16'h0000;
            @(negedge clk);
            config_reg_enable = 1'b0;
            @(negedge clk);
            chk(bus_q, 16'h9D2F);
            chk(ref_q, 16'h0017);
        end
        host.burst(1'b0, lat, wlat);
        chk(16'(lat), 16'h0028);
        $display("test registers done");
        for (int c = 2; c < 5; c++) begin
            burst_chk(1'b0, 3'(c), 1'b0, 1'b1, 1'b1);
            burst_chk(1'b0, 3'(c), 1'b1, 1'b0, 1'b0);
        end
        for (int i = 0; i < 6; i++)
            burst_chk(1'b1, (i == 5) ? 3'h0 : 3'(i + 2), 1'b1, i[0], !i[0]);
        $display("test latency done");
        acc(1'b0, 1'b0, 1'b1, 16'h0005);
        host.set_cs(1'b1);
        repeat (3) @(negedge clk);
        chk({15'h0, sleep}, 16'h0001);
        acc(1'b1, 1'b0, 1'b1, 16'h0017);
        chk(ref_q, 16'h0005);
        host.set_cs(1'b0);
        repeat (7) @(negedge clk);
        chk({15'h0, sleep}, 16'h0000);
        chk(ref_q, 16'h0015);
        chk(bus_q, 16'h411F);
        chk({15'h0, init_busy}, 16'h0001);
        repeat (10) @(negedge clk);
        chk({15'h0, init_busy}, 16'h0000);
        $display("test deep sleep done");
        report_and_stop();
    end
endmodule
`default_nettype wire
